// ==== rtl/gfs_consts.svh ====
// Offsets, field positions, codes and reset values of the pin 7 / frame sync block.
// Assumes inclusion by bare name from the top module.
`ifndef GFS_CONSTS_SVH
`define GFS_CONSTS_SVH
// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define GFS_IDX_PIN7_CTL 6'h17
`define GFS_IDX_FRAME_SYNC_CONTROL 6'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GFS_PIN7_SEL_LSB 5
`define GFS_PIN7_SRC_LSB 2
`define GFS_PIN7_VAL_BIT 1
`define GFS_PIN7_EN_BIT 0
`define GFS_SYNC_SOURCE_MODE_LSB 4
`define GFS_SYNC_SINGLE_PULSE_BIT 3
`define GFS_FS_INIT_BIT 2
`define GFS_FS_PMODE_BIT 1
`define GFS_FS_GEN_BIT 0
// ----------------------------------------
// Source and select codes
// ----------------------------------------
`define GFS_SRC_STATUS 3'h4
`define GFS_SRC_TX 3'h6
`define GFS_SEL_LOCK 3'h4
`define GFS_SEL_PASS 3'h5
`define GFS_SEL_FV 3'h6
`define GFS_SEL_LV 3'h7
`define GFS_ST_VALUE 3'h0
`define GFS_ST_LOCK_OR 3'h1
`define GFS_ST_PASS_AND 3'h2
`define GFS_ST_FSYNC 3'h3
`define GFS_TX_PASS_AND 3'h0
`define GFS_TX_PASS_OR 3'h1
`define GFS_TX_FV 3'h2
`define GFS_TX_LV 3'h3
`define GFS_TX_SYNCED 3'h4
`define GFS_TX_IRQ 3'h5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GFS_PIN7_CTL_RST 8'h00
`define GFS_FRAME_SYNC_CONTROL_RST 8'h00
`endif

// ==== rtl/gfs_pkg.sv ====
// Types of the pin 7 output and frame sync generator block.
// Assumes the constants header is on the include path.
package gfs_pkg;
    // ----------------------------------------
    // Register layouts
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] sel;
        logic [2:0] src;
        logic val;
        logic en;
    } gfs_pin_ctl_t;

    typedef struct packed {
        logic [3:0] mode;
        logic single;
        logic init;
        logic pmode;
        logic gen;
    } gfs_frame_sync_control_t;

    // ----------------------------------------
    // Receive port status, one bit per port
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] lock;
        logic [3:0] pass;
        logic [3:0] fv;
        logic [3:0] lv;
        logic [3:0] enabled;
    } gfs_rx_stat_t;

    // Gray order: idle, run, single.
    typedef enum logic [1:0] {
        GFS_IDLE = 2'b00,
        GFS_RUN = 2'b01,
        GFS_SINGLE = 2'b11
    } gfs_state_t;
endpackage

// ==== rtl/gfs_top.sv ====
// Pin 7 output multiplexer and frame sync pulse generator with an Avalon-MM slave.
// Assumes status inputs and timing ticks come from logic on i_clk; GPIO pins are asynchronous.
`timescale 1ns/10ps
`include "gfs_consts.svh"

module gfs_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Avalon-MM slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Receive port status
    input wire logic [15:0] i_rx_gpio,
    input wire gfs_pkg::gfs_rx_stat_t i_rx_stat,
    // Video transmit port status
    input wire logic [3:0] i_tx_port_sel,
    input wire logic i_tx_fv,
    input wire logic i_tx_lv,
    input wire logic i_tx_synced,
    input wire logic i_tx_irq,
    // Timing ticks and external pins
    input wire logic [3:0] i_bc_frame_tick,
    input wire logic i_ref25_tick,
    input wire logic [7:0] i_gpio_in,
    input wire logic [15:0] i_sync_high_period,
    input wire logic [15:0] i_sync_low_period,
    // Outputs
    output logic o_pin7_out,
    output logic o_pin7_oe,
    output logic o_frame_sync_pulse
);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    gfs_pkg::gfs_pin_ctl_t pin7_output_control_q;
    gfs_pkg::gfs_frame_sync_control_t frame_sync_control_q;
    logic ack_q;
    logic single_req_q;
    logic [31:0] rdata_q;
    logic req;
    logic accept;
    logic hit_pin;
    logic hit_fs;
    logic wr_low;

    assign req = i_avs_read | i_avs_write;
    assign accept = req & ack_q;
    assign o_avs_waitrequest = req & ~ack_q;
    assign o_avs_readdata = rdata_q;
    assign hit_pin = (i_avs_address == {`GFS_IDX_PIN7_CTL, 2'b00});
    assign hit_fs = (i_avs_address == {`GFS_IDX_FRAME_SYNC_CONTROL, 2'b00});
    assign wr_low = accept & i_avs_write & i_avs_byteenable[0];

    // Every access waits exactly one cycle so read data can come from a flop.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            if (hit_pin) begin
                rdata_q <= {24'h00_0000, pin7_output_control_q};
            end else if (hit_fs) begin
                rdata_q <= {24'h00_0000, frame_sync_control_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin7_output_control_q <= `GFS_PIN7_CTL_RST;
        end else if (wr_low && hit_pin) begin
            pin7_output_control_q <= gfs_pkg::gfs_pin_ctl_t'(i_avs_writedata[7:0]);
        end
    end

    // The single bit is never stored, so it always reads back as zero.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_sync_control_q <= `GFS_FRAME_SYNC_CONTROL_RST;
            single_req_q <= 1'b0;
        end else begin
            single_req_q <= wr_low & hit_fs & i_avs_writedata[`GFS_SYNC_SINGLE_PULSE_BIT];
            if (wr_low && hit_fs) begin
                frame_sync_control_q <= gfs_pkg::gfs_frame_sync_control_t'({i_avs_writedata[7:4], 1'b0,
                    i_avs_writedata[2:0]});
            end
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [7:0] gpio_meta_q;
    logic [7:0] gpio_sync_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gpio_meta_q <= 8'h00;
            gpio_sync_q <= 8'h00;
        end else begin
            gpio_meta_q <= i_gpio_in;
            gpio_sync_q <= gpio_meta_q;
        end
    end

    // ----------------------------------------
    // Frame sync generator
    // ----------------------------------------
    gfs_pkg::gfs_state_t state_q;
    logic level_q;
    logic [23:0] cnt_q;
    logic tick;
    logic external;
    logic [23:0] period;
    logic phase_done;
    logic fs_d;

    assign external = frame_sync_control_q.mode[3];

    always_comb begin
        tick = 1'b0;
        if (frame_sync_control_q.mode[3:2] == 2'b01) begin
            tick = i_ref25_tick;
        end else if (!frame_sync_control_q.mode[3]) begin
            tick = i_bc_frame_tick[frame_sync_control_q.mode[1:0]];
        end
    end

    // Period values are one less than the phase length in ticks.
    always_comb begin
        if (frame_sync_control_q.pmode) begin
            period = {i_sync_high_period[7:0], i_sync_low_period};
        end else if (level_q) begin
            period = {8'h00, i_sync_high_period};
        end else begin
            period = {8'h00, i_sync_low_period};
        end
    end

    assign phase_done = tick & (cnt_q == period);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= gfs_pkg::GFS_IDLE;
            level_q <= 1'b0;
            cnt_q <= 24'h00_0000;
        end else begin
            case (state_q)
                gfs_pkg::GFS_IDLE: begin
                    cnt_q <= 24'h00_0000;
                    level_q <= frame_sync_control_q.init;
                    if (frame_sync_control_q.gen) begin
                        state_q <= gfs_pkg::GFS_RUN;
                    end else if (single_req_q) begin
                        state_q <= gfs_pkg::GFS_SINGLE;
                        level_q <= ~frame_sync_control_q.init;
                    end
                end
                gfs_pkg::GFS_RUN: begin
                    if (!frame_sync_control_q.gen) begin
                        state_q <= gfs_pkg::GFS_IDLE;
                    end else if (phase_done) begin
                        cnt_q <= 24'h00_0000;
                        level_q <= ~level_q;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 24'h00_0001;
                    end
                end
                gfs_pkg::GFS_SINGLE: begin
                    if (phase_done) begin
                        state_q <= gfs_pkg::GFS_IDLE;
                        cnt_q <= 24'h00_0000;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 24'h00_0001;
                    end
                end
                default: begin
                    state_q <= gfs_pkg::GFS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        if (external) begin
            fs_d = gpio_sync_q[frame_sync_control_q.mode[2:0]];
        end else if (state_q == gfs_pkg::GFS_IDLE) begin
            fs_d = frame_sync_control_q.init;
        end else begin
            fs_d = level_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_frame_sync_pulse <= 1'b0;
        end else begin
            o_frame_sync_pulse <= fs_d;
        end
    end

    // ----------------------------------------
    // Pin 7 output multiplexer
    // ----------------------------------------
    logic pin_d;
    logic [1:0] port;
    logic [2:0] sel;
    logic [3:0] tx_pass;

    assign port = pin7_output_control_q.src[1:0];
    assign sel = pin7_output_control_q.sel;
    assign tx_pass = i_rx_stat.pass | ~i_tx_port_sel;

    always_comb begin
        pin_d = 1'b0;
        if (!pin7_output_control_q.src[2]) begin
            case (sel)
                `GFS_SEL_LOCK: pin_d = i_rx_stat.lock[port];
                `GFS_SEL_PASS: pin_d = i_rx_stat.pass[port];
                `GFS_SEL_FV: pin_d = i_rx_stat.fv[port];
                `GFS_SEL_LV: pin_d = i_rx_stat.lv[port];
                default: pin_d = i_rx_gpio[{port, sel[1:0]}];
            endcase
        end else if (pin7_output_control_q.src == `GFS_SRC_STATUS) begin
            case (sel)
                `GFS_ST_VALUE: pin_d = pin7_output_control_q.val;
                `GFS_ST_LOCK_OR: pin_d = |(i_rx_stat.lock & i_rx_stat.enabled);
                `GFS_ST_PASS_AND: pin_d = &(i_rx_stat.pass | ~i_rx_stat.enabled);
                `GFS_ST_FSYNC: pin_d = o_frame_sync_pulse;
                default: pin_d = 1'b0;
            endcase
        end else if (pin7_output_control_q.src == `GFS_SRC_TX) begin
            case (sel)
                `GFS_TX_PASS_AND: pin_d = &tx_pass;
                `GFS_TX_PASS_OR: pin_d = |(i_rx_stat.pass & i_tx_port_sel);
                `GFS_TX_FV: pin_d = i_tx_fv;
                `GFS_TX_LV: pin_d = i_tx_lv;
                `GFS_TX_SYNCED: pin_d = i_tx_synced;
                `GFS_TX_IRQ: pin_d = i_tx_irq;
                default: pin_d = 1'b0;
            endcase
        end
    end

    // The driver enable is registered alongside the data so both change on one edge.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pin7_out <= 1'b0;
            o_pin7_oe <= 1'b0;
        end else begin
            o_pin7_out <= pin_d;
            o_pin7_oe <= pin7_output_control_q.en;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_drive_enable_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (wr_low && hit_pin) |-> ##2 (o_pin7_oe == $past(i_avs_writedata[0], 2)))
        else $error("pin drive enable does not follow write");

    a_value_drive: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pin7_output_control_q.src == 3'h4 && sel == 3'h0) |=> (o_pin7_out == $past(pin7_output_control_q.val)))
        else $error("pin does not show value bit");

    a_rx_gpio_pass: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!pin7_output_control_q.src[2] && !sel[2]) |=> (o_pin7_out == $past(i_rx_gpio[{port, sel[1:0]}])))
        else $error("pin does not show remote gpio");

    a_rx_lock_sel: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!pin7_output_control_q.src[2] && sel == 3'h4) |=> (o_pin7_out == $past(i_rx_stat.lock[port])))
        else $error("pin does not show port lock");

    a_lock_or: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pin7_output_control_q.src == 3'h4 && sel == 3'h1 && (i_rx_stat.lock & i_rx_stat.enabled) == 4'h0)
        |=> !o_pin7_out)
        else $error("lock OR high with no enabled lock");

    a_pass_and: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pin7_output_control_q.src == 3'h4 && sel == 3'h2 && i_rx_stat.enabled == 4'hf)
        |=> (o_pin7_out == $past(&i_rx_stat.pass)))
        else $error("pass AND wrong");

    a_tx_pass_or: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pin7_output_control_q.src == 3'h6 && sel == 3'h1)
        |=> (o_pin7_out == $past(|(i_rx_stat.pass & i_tx_port_sel))))
        else $error("transmit pass OR wrong");

    a_tx_irq_sel: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pin7_output_control_q.src == 3'h6 && sel == 3'h5) |=> (o_pin7_out == $past(i_tx_irq)))
        else $error("transmit interrupt not shown");

    a_reserved_src: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pin7_output_control_q.src == 3'h5 || pin7_output_control_q.src == 3'h7) |=> !o_pin7_out)
        else $error("reserved source drives high");

    a_single_read_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (accept && i_avs_read && hit_fs) |-> !o_avs_readdata[3])
        else $error("single bit reads back as one");

    a_single_start: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == gfs_pkg::GFS_IDLE && single_req_q && !frame_sync_control_q.gen && !external)
        |=> (state_q == gfs_pkg::GFS_SINGLE) ##1 (o_frame_sync_pulse != frame_sync_control_q.init))
        else $error("single pulse not started");

    a_idle_level: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == gfs_pkg::GFS_IDLE && !external && $stable(frame_sync_control_q))
        |=> (o_frame_sync_pulse == $past(frame_sync_control_q.init)))
        else $error("idle level differs from initial level");

    a_gen_stop: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == gfs_pkg::GFS_RUN && !frame_sync_control_q.gen) |=> (state_q == gfs_pkg::GFS_IDLE))
        else $error("generator keeps running when disabled");

    a_ext_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        external |=> (o_frame_sync_pulse == $past(gpio_sync_q[frame_sync_control_q.mode[2:0]])))
        else $error("external sync not followed");

    a_zero_period: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == gfs_pkg::GFS_RUN && frame_sync_control_q.gen && tick && period == 24'h00_0000)
        |=> (level_q != $past(level_q)))
        else $error("zero period not one tick");

    a_wait_bound: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        req |-> ##[0:1] !o_avs_waitrequest)
        else $error("waitrequest held too long");
endmodule

// ==== tb/gfs_far_model.sv ====
// Far-side model: remote frame ticks, the reference tick and external sync pins.
// Assumes one clock shared with the block; the bench commands the pin levels.
`timescale 1ns/10ps

module gfs_far_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Bench commands
    input wire logic [7:0] i_pin_level,
    // Ticks and pins
    output logic [3:0] o_bc_frame_tick,
    output logic o_ref25_tick,
    output logic [7:0] o_gpio_in
);
    logic [3:0] cnt_q [5];

    // Port p ticks every p+2 cycles and the reference every 3, so a wrong source shows as a wrong width, except port 1 and the reference, which share one.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < 5; i++) begin
                cnt_q[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                cnt_q[i] <= (cnt_q[i] >= ((i < 4) ? i + 1 : 2)) ? 4'h0 : cnt_q[i] + 4'h1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_bc_frame_tick[i] = (cnt_q[i] == 4'(i + 1));
        end
        o_ref25_tick = (cnt_q[4] == 4'h2);
    end

    // Pins are registered here, so they change once per cycle, as a real pin could.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_gpio_in <= 8'h00;
        end else begin
            o_gpio_in <= i_pin_level;
        end
    end
endmodule

// ==== tb/gpio_frame_sync_pulse_control_tb_top.sv ====
// Self-checking bench of the pin 7 multiplexer and frame sync generator.
// Assumes the far-side model supplies ticks and pins; the bench drives status and periods.
`timescale 1ns/10ps

module gpio_frame_sync_pulse_control_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h1;
    logic [31:0] rdata;
    logic wait_req;
    logic [15:0] rx_gpio = 16'h0;
    gfs_pkg::gfs_rx_stat_t rx_stat = '0;
    logic [3:0] tx_sel = 4'h0;
    logic tx_fv = 1'b0;
    logic tx_lv = 1'b0;
    logic tx_sy = 1'b0;
    logic tx_irq = 1'b0;
    logic [3:0] bc_tick;
    logic ref_tick;
    logic [7:0] gpio_in;
    logic [7:0] pin_lvl = 8'h00;
    logic [15:0] hi_p = 16'h0001;
    logic [15:0] lo_p = 16'h0002;
    logic pin_out;
    logic pin_oe;
    logic fs;
    int num_errors = 0;
    int total_checks = 0;

    always #25 clk = ~clk;

    gfs_top uut (.i_clk(clk), .i_arst_n(arst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .i_rx_gpio(rx_gpio), .i_rx_stat(rx_stat), .i_tx_port_sel(tx_sel), .i_tx_fv(tx_fv), .i_tx_lv(tx_lv),
        .i_tx_synced(tx_sy), .i_tx_irq(tx_irq), .i_bc_frame_tick(bc_tick), .i_ref25_tick(ref_tick),
        .i_gpio_in(gpio_in), .i_sync_high_period(hi_p), .i_sync_low_period(lo_p), .o_pin7_out(pin_out),
        .o_pin7_oe(pin_oe), .o_frame_sync_pulse(fs));

    gfs_far_model far (.i_clk(clk), .i_arst_n(arst_n), .i_pin_level(pin_lvl), .o_bc_frame_tick(bc_tick),
        .o_ref25_tick(ref_tick), .o_gpio_in(gpio_in));

    // ----------------------------------------
    // Checks and bus cycles
    // ----------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Only the watchdog ends a wait that never finishes.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk_val(q, {24'h0, exp});
    endtask

    task automatic run_len(input logic lvl, output int len);
        int n;
        n = 0;
        while (fs !== lvl && n < 400) begin
            @(posedge clk);
            n++;
        end
        len = 0;
        while (fs === lvl && len < 400) begin
            @(posedge clk);
            len++;
        end
    endtask

    function automatic logic exp_pin(input logic [2:0] src, input logic [2:0] sel, input logic val);
        if (!src[2]) begin
            if (!sel[2]) return rx_gpio[{src[1:0], sel[1:0]}];
            case (sel[1:0])
                2'h0: return rx_stat.lock[src[1:0]];
                2'h1: return rx_stat.pass[src[1:0]];
                2'h2: return rx_stat.fv[src[1:0]];
                default: return rx_stat.lv[src[1:0]];
            endcase
        end
        if (src == 3'h4) begin
            case (sel)
                3'h0: return val;
                3'h1: return |(rx_stat.lock & rx_stat.enabled);
                3'h2: return &(rx_stat.pass | ~rx_stat.enabled);
                default: return 1'b0;
            endcase
        end
        if (src != 3'h6) return 1'b0;
        case (sel)
            3'h0: return &(rx_stat.pass | ~tx_sel);
            3'h1: return |(rx_stat.pass & tx_sel);
            3'h2: return tx_fv;
            3'h3: return tx_lv;
            3'h4: return tx_sy;
            3'h5: return tx_irq;
            default: return 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd_chk(8'h5c, 8'h00);
        rd_chk(8'h60, 8'h00);
        chk_bit(pin_oe, 1'b0);
        chk_bit(fs, 1'b0);
        wr_reg(8'h5c, 8'ha5);
        rd_chk(8'h5c, 8'ha5);
        be <= 4'h0;
        wr_reg(8'h5c, 8'h00);
        be <= 4'h1;
        rd_chk(8'h5c, 8'ha5);
        wr_reg(8'h64, 8'hff);
        rd_chk(8'h64, 8'h00);
        repeat (2) @(posedge clk);
        chk_bit(pin_oe, 1'b1);
        wr_reg(8'h5c, 8'h00);
        repeat (2) @(posedge clk);
        chk_bit(pin_oe, 1'b0);
    endtask

    task automatic t_mux;
        for (int b = 0; b < 2; b++) begin
            rx_gpio <= b ? 16'ha5c3 : 16'h5a3c;
            rx_stat <= b ? {4'b1000, 4'b0011, 4'b0110, 4'b1001, 4'b0011} : {4'b0101, 4'b1110, 4'b1001, 4'b0110, 4'b0011};
            tx_sel <= b ? 4'b1100 : 4'b0110;
            {tx_fv, tx_lv, tx_sy, tx_irq} <= b ? 4'b0101 : 4'b1010;
            for (int s = 0; s < 64; s++) begin
                if (s[5:3] != 3'h4 || s[2:0] != 3'h3) begin
                    wr_reg(8'h5c, {s[2:0], s[5:3], s[0] ^ s[3] ^ b[0], 1'b1});
                    repeat (2) @(posedge clk);
                    chk_bit(pin_out, exp_pin(s[5:3], s[2:0], s[0] ^ s[3] ^ b[0]));
                end
            end
        end
    endtask

    task automatic t_gen;
        int h;
        int l;
        for (int m = 0; m < 8; m++) begin
            wr_reg(8'h60, {m[3:0], 4'h1});
            run_len(1'b1, h);
            run_len(1'b0, l);
            chk_val(h, 2 * ((m < 4) ? m + 2 : 3));
            chk_val(l, 3 * ((m < 4) ? m + 2 : 3));
            wr_reg(8'h60, {m[3:0], 4'h0});
            repeat (3) @(posedge clk);
            chk_bit(fs, 1'b0);
        end
        wr_reg(8'h60, 8'h44);
        repeat (3) @(posedge clk);
        chk_bit(fs, 1'b1);
        wr_reg(8'h60, 8'h45);
        run_len(1'b0, l);
        run_len(1'b1, h);
        chk_val(l, 9);
        chk_val(h, 6);
        hi_p <= 16'h0100;
        wr_reg(8'h60, 8'h43);
        run_len(1'b1, h);
        run_len(1'b0, l);
        chk_val(h, 9);
        chk_val(l, 9);
        wr_reg(8'h60, 8'h40);
        hi_p <= 16'h0001;
        lo_p <= 16'h0000;
        wr_reg(8'h60, 8'h41);
        run_len(1'b1, h);
        run_len(1'b0, l);
        chk_val(h, 6);
        chk_val(l, 3);
        wr_reg(8'h60, 8'h40);
        lo_p <= 16'h0002;
    endtask

    task automatic t_single;
        int h;
        int ones;
        // Raised one cycle after a reference tick, the pulse starts one cycle before the next tick.
        do begin
            @(posedge clk);
        end while (ref_tick !== 1'b1);
        wr_reg(8'h60, 8'h48);
        run_len(1'b1, h);
        chk_val(h, 5);
        rd_chk(8'h60, 8'h40);
        ones = 0;
        repeat (60) begin
            @(posedge clk);
            if (fs !== 1'b0) ones++;
        end
        chk_val(ones, 0);
    endtask

    task automatic t_ext;
        wr_reg(8'h5c, 8'h71);
        for (int k = 0; k < 8; k++) begin
            pin_lvl <= ~(8'h01 << k);
            wr_reg(8'h60, {1'b1, k[2:0], 4'h0});
            repeat (6) @(posedge clk);
            chk_bit(fs, 1'b0);
            chk_bit(pin_out, 1'b0);
            pin_lvl <= 8'h01 << k;
            repeat (6) @(posedge clk);
            chk_bit(fs, 1'b1);
            chk_bit(pin_out, 1'b1);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A full run needs some 1200 cycles; the watchdog allows a wide margin.
    initial begin
        #(50 * 30000);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_mux();
        t_gen();
        t_single();
        t_ext();
        final_report();
    end
endmodule
